/* hdl/nco_regs_pkg.sv */
// Package for the oscillator accumulator and increment register bank
// Assumes an 8-bit register port and a single 250 MHz system clock
package nco_regs_pkg;
   // ==========================================================
   // Widths
   localparam int PHASE_W = 20;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int UPPER_W = 4;
   // ==========================================================
   // Register offsets
   localparam logic [3:0] OFS_ACC_LOW = 4'h0;
   localparam logic [3:0] OFS_ACC_HIGH = 4'h1;
   localparam logic [3:0] OFS_ACC_UPPER = 4'h2;
   localparam logic [3:0] OFS_STEP_LOW = 4'h3;
   localparam logic [3:0] OFS_STEP_HIGH = 4'h4;
   localparam logic [3:0] OFS_STEP_UPPER = 4'h5;
   localparam logic [3:0] OFS_CONTROL = 4'h6;
   localparam logic [3:0] OFS_STATUS = 4'h7;
   // ==========================================================
   // Field positions and reset values
   localparam int CTL_ENABLE_BIT = 7;
   localparam int CTL_PFM_BIT = 0;
   localparam int CTL_PWS_LSB = 4;
   localparam int STS_OUT_BIT = 0;
   localparam int STS_PEND_BIT = 1;
   localparam logic [7:0] RST_ACC_BYTE = 8'h00;
   localparam logic [7:0] RST_STEP_LOW = 8'h01;
   localparam logic [7:0] RST_STEP_HIGH = 8'h00;
   localparam logic [3:0] RST_STEP_UPPER = 4'h0;
   localparam logic [2:0] RST_PWS = 3'h0;
   localparam logic [7:0] READ_IDLE = 8'h00;
   // Pulse width counter width (up to 128 periods)
   localparam int PW_CNT_W = 8;
   localparam logic [7:0] PW_ONE = 8'h01;
   // Output modes
   typedef enum logic [1:0] {
      MODE_TOGGLE_type_dummy = 2'b01,
      MODE_PULSE = 2'b10
   } out_mode_type;
endpackage : nco_regs_pkg

/* hdl/nco_step_if.sv */
// Interface carrying the increment and its reload request inside the block
// Assumes both ends run on sys_clk
`timescale 1ns/10ps
interface nco_step_if;
   import nco_regs_pkg::*;
   logic [PHASE_W-1:0] step_value;   // Increment assembled from the three bytes
   logic reload_req;                 // Level: low byte written, reload pending
   logic reload_done;                // Pulse: shadow has taken the value
   logic [PHASE_W-1:0] shadow_value; // Increment the accumulator uses
   modport regs (output step_value, output reload_req, input reload_done,
      input shadow_value);
   modport shadow (input step_value, input reload_req, output reload_done,
      output shadow_value);
endinterface : nco_step_if

/* hdl/nco_step_shadow.sv */
// Increment shadow buffer, reloaded on a falling source clock edge
// Assumes the source clock is a synchronous input level
`timescale 1ns/10ps
module nco_step_shadow
   import nco_regs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic src_fall,
   nco_step_if.shadow step
);
   // ==========================================================
   // Shadow register
   logic [PHASE_W-1:0] shadow_q;
   logic [PHASE_W-1:0] shadow_d;
   wire take_w = step.reload_req & src_fall; // First falling edge after write
   assign shadow_d = take_w ? step.step_value : shadow_q;
   assign step.shadow_value = shadow_q;
   assign step.reload_done = take_w;
   // Reset matches the reset value of the increment bytes
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         shadow_q <= {RST_STEP_UPPER, RST_STEP_HIGH, RST_STEP_LOW};
      end else begin
         shadow_q <= shadow_d;
      end
   end
endmodule : nco_step_shadow

/* hdl/nco_pulse_out.sv */
// Output stage: toggle on overflow, or fixed-width pulse in pulse mode
// Assumes overflow and rise events are single-cycle pulses
`timescale 1ns/10ps
module nco_pulse_out
   import nco_regs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic pfm_mode,
   input wire logic [2:0] pws,
   input wire logic src_rise,
   input wire logic overflow,
   output logic out_level
);
   logic out_q;
   logic out_d;
   logic [PW_CNT_W-1:0] cnt_q;
   logic [PW_CNT_W-1:0] cnt_d;
   // Width of 2^pws source periods; only used in pulse mode
   wire [PW_CNT_W-1:0] width_w = PW_ONE << pws;
   // Next state of output and width counter
   always_comb begin
      out_d = out_q;
      cnt_d = cnt_q;
      if (!enable) begin
         out_d = 1'b0;
         cnt_d = '0;
      end else if (overflow) begin
         if (pfm_mode) begin
            out_d = 1'b1;                  // Pulse starts
            cnt_d = width_w;
         end else begin
            out_d = ~out_q;                // Toggle mode ignores width
         end
      end else if (pfm_mode && out_q && src_rise) begin
         // Width longer than overflow period is undefined
         cnt_d = cnt_q - PW_ONE;
         if (cnt_q == PW_ONE) begin
            out_d = 1'b0;
         end
      end
   end
   // Output registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         out_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         out_q <= out_d;
         cnt_q <= cnt_d;
      end
   end
   assign out_level = out_q;
endmodule : nco_pulse_out

/* hdl/nco_accumulator_increment_regs.sv */
// Phase accumulator and phase increment register bank of the oscillator
// Assumes an 8-bit register port and a source clock sampled on sys_clk
//
// Behaviour
// - Accumulator is 20 bits over three bytes
// - Upper bytes bits 7..4 read zero
// - Accumulator runs freely; no atomic snapshot
// - Increment is three bytes forming 20 bits
// - Shadow reloads on falling edge after low write
// - Resets clear bytes; increment low resets one
// - Pulse width applies only in pulse mode
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module nco_accumulator_increment_regs
   import nco_regs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic oscillator_source_clock,
   output logic overflow_pulse,
   output logic oscillator_out
);
   // ==========================================================
   // Address decode
   wire wr_acc_low = reg_write && (reg_addr == OFS_ACC_LOW);
   wire wr_acc_high = reg_write && (reg_addr == OFS_ACC_HIGH);
   wire wr_acc_upper = reg_write && (reg_addr == OFS_ACC_UPPER);
   wire wr_step_low = reg_write && (reg_addr == OFS_STEP_LOW);
   wire wr_step_high = reg_write && (reg_addr == OFS_STEP_HIGH);
   wire wr_step_upper = reg_write && (reg_addr == OFS_STEP_UPPER);
   wire wr_control = reg_write && (reg_addr == OFS_CONTROL);

   // ==========================================================
   // Control register
   logic oscillator_module_enable_q;    // Module runs when high
   logic pulse_frequency_mode_select_q; // Pulse mode when high
   logic [2:0] output_pulse_width_select_q;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         oscillator_module_enable_q <= 1'b0;
         pulse_frequency_mode_select_q <= 1'b0;
         output_pulse_width_select_q <= RST_PWS;
      end else if (wr_control) begin
         oscillator_module_enable_q <= reg_wdata[CTL_ENABLE_BIT];
         pulse_frequency_mode_select_q <= reg_wdata[CTL_PFM_BIT];
         output_pulse_width_select_q <= reg_wdata[CTL_PWS_LSB +: 3];
      end
   end

   // ==========================================================
   // Source clock edge detection
   logic src_q;     // Previous sample of the source clock
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         src_q <= 1'b0;
      end else begin
         src_q <= oscillator_source_clock;
      end
   end
   wire src_rise = oscillator_source_clock & ~src_q;
   wire src_fall = ~oscillator_source_clock & src_q;

   // ==========================================================
   // Increment byte registers
   logic [7:0] step_low_q;
   logic [7:0] step_high_q;
   logic [UPPER_W-1:0] step_upper_q;   // Only bits 3..0 exist
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         step_low_q <= RST_STEP_LOW;     // Low byte resets to one
         step_high_q <= RST_STEP_HIGH;
         step_upper_q <= RST_STEP_UPPER;
      end else begin
         if (wr_step_low) begin
            step_low_q <= reg_wdata;
         end
         if (wr_step_high) begin
            step_high_q <= reg_wdata;
         end
         if (wr_step_upper) begin
            step_upper_q <= reg_wdata[UPPER_W-1:0];
         end
      end
   end

   // Reload pending flag: a new low write wins over the completion
   nco_step_if step ();
   logic pend_q;
   logic pend_d;
   assign pend_d = wr_step_low ? 1'b1 : (step.reload_done ? 1'b0 : pend_q);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pend_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
      end
   end
   // Full value assembled; software orders upper and high first
   assign step.step_value = {step_upper_q, step_high_q, step_low_q};
   assign step.reload_req = pend_q;

   nco_step_shadow u_shadow (
      .sys_clk(sys_clk),
      .rst(rst),
      .src_fall(src_fall),
      .step(step)
   );

   // ==========================================================
   // Phase accumulator
   logic [PHASE_W-1:0] acc_q;
   logic [PHASE_W-1:0] acc_d;
   logic ovf_q;
   logic ovf_d;
   wire [PHASE_W:0] acc_sum = {1'b0, acc_q} + {1'b0, step.shadow_value};
   wire acc_step = oscillator_module_enable_q & src_rise;
   // Next accumulator value: byte writes only defined while stopped
   always_comb begin
      acc_d = acc_q;
      ovf_d = 1'b0;
      if (acc_step) begin
         acc_d = acc_sum[PHASE_W-1:0];
         ovf_d = acc_sum[PHASE_W];          // Carry out of bit 19
      end
      // Writes while running give undefined results
      if (wr_acc_low) begin
         acc_d[7:0] = reg_wdata;
      end
      if (wr_acc_high) begin
         acc_d[15:8] = reg_wdata;
      end
      if (wr_acc_upper) begin
         acc_d[PHASE_W-1:16] = reg_wdata[UPPER_W-1:0];
      end
   end
   // Accumulator updates freely, no snapshot for byte reads
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         acc_q <= '0;
         ovf_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         ovf_q <= ovf_d;
      end
   end
   assign overflow_pulse = ovf_q;

   // ==========================================================
   // Output stage
   nco_pulse_out u_out (
      .sys_clk(sys_clk),
      .rst(rst),
      .enable(oscillator_module_enable_q),
      .pfm_mode(pulse_frequency_mode_select_q),
      .pws(output_pulse_width_select_q),
      .src_rise(src_rise),
      .overflow(ovf_q),
      .out_level(oscillator_out)
   );

   // ==========================================================
   // Read mux; upper bytes pad with zero
   logic [DATA_W-1:0] rd_mux;
   always_comb begin
      case (reg_addr)
         OFS_ACC_LOW: rd_mux = acc_q[7:0];
         OFS_ACC_HIGH: rd_mux = acc_q[15:8];
         OFS_ACC_UPPER: rd_mux = {4'h0, acc_q[PHASE_W-1:16]};
         OFS_STEP_LOW: rd_mux = step_low_q;
         OFS_STEP_HIGH: rd_mux = step_high_q;
         OFS_STEP_UPPER: rd_mux = {4'h0, step_upper_q};
         // Enable in bit 7, width select in bits 6..4, pulse mode in bit 0
         OFS_CONTROL: rd_mux = {oscillator_module_enable_q, output_pulse_width_select_q,
            3'h0, pulse_frequency_mode_select_q};
         OFS_STATUS: rd_mux = {6'h00, pend_q, oscillator_out};
         default: rd_mux = READ_IDLE;
      endcase
   end
   // Read data stands one cycle after the strobe only
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= READ_IDLE;
      end else begin
         reg_rdata <= reg_read ? rd_mux : READ_IDLE;
      end
   end
endmodule : nco_accumulator_increment_regs

/* dv/nco_regs_assertions.sv */
// Checker for the accumulator and increment register bank
// Assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
module nco_regs_checker
   import nco_regs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic oscillator_source_clock,
   input wire logic overflow_pulse,
   input wire logic oscillator_out
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // Mirrors of what software last wrote
   logic en_q; // Enable bit
   logic [7:0] lo_q; // Low increment byte
   logic [7:0] hi_q; // High increment byte
   // Follow the writes, starting from the reset values
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         en_q <= 1'b0;
         lo_q <= RST_STEP_LOW;
         hi_q <= RST_STEP_HIGH;
      end else if (reg_write) begin
         if (reg_addr == OFS_CONTROL) en_q <= reg_wdata[CTL_ENABLE_BIT];
         if (reg_addr == OFS_STEP_LOW) lo_q <= reg_wdata;
         if (reg_addr == OFS_STEP_HIGH) hi_q <= reg_wdata;
      end
   end
   // ==========================================================
   // Assertions
   a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == READ_IDLE)
      else $error("read data not zero outside a read");
   a_acc_upper_zero: assert property (reg_read && reg_addr == OFS_ACC_UPPER |=>
      reg_rdata[7:4] == 4'h0) else $error("accumulator upper bits 7:4 not zero");
   a_step_upper_zero: assert property (reg_read && reg_addr == OFS_STEP_UPPER |=>
      reg_rdata[7:4] == 4'h0) else $error("increment upper bits 7:4 not zero");
   a_step_low_back: assert property (reg_read && reg_addr == OFS_STEP_LOW |=>
      reg_rdata == $past(lo_q)) else $error("increment low byte read back wrong");
   a_step_high_back: assert property (reg_read && reg_addr == OFS_STEP_HIGH |=>
      reg_rdata == $past(hi_q)) else $error("increment high byte read back wrong");
   a_ovf_one_cycle: assert property (overflow_pulse |=> !overflow_pulse)
      else $error("overflow pulse longer than one cycle");
   a_ovf_src_edge: assert property (overflow_pulse |-> $past(oscillator_source_clock) &&
      !$past(oscillator_source_clock, 2)) else $error("overflow without a source edge");
   a_ovf_enabled: assert property (overflow_pulse |-> $past(en_q))
      else $error("overflow while disabled");
   // Main scenarios reached
   c_overflow: cover property (overflow_pulse);
   c_step_low_read: cover property (reg_read && reg_addr == OFS_STEP_LOW);
   c_out_rise: cover property ($rose(oscillator_out));
endmodule : nco_regs_checker

bind nco_accumulator_increment_regs nco_regs_checker u_chk (.sys_clk, .rst, .reg_addr,
   .reg_wdata, .reg_write, .reg_read, .reg_rdata, .oscillator_source_clock,
   .overflow_pulse, .oscillator_out);

/* dv/nco_accumulator_increment_regs_tb.sv */
// Self-checking bench for the accumulator and increment register bank
// Assumes the register port and source clock are driven from this bench
`timescale 1ns/10ps
module nco_accumulator_increment_regs_tb;
   import nco_regs_pkg::*;
   logic sys_clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, src_clk = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic overflow_pulse, oscillator_out;
   int err_total = 0, check_count = 0, ovf_n = 0;
   nco_accumulator_increment_regs dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .oscillator_source_clock(src_clk),
      .overflow_pulse(overflow_pulse), .oscillator_out(oscillator_out));
   // ==========================================================
   // Clock at 250 MHz and overflow counter
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (overflow_pulse === 1'b1) ovf_n++;
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      // Let one edge pass so the next call never reassigns the strobe
      @(posedge sys_clk);
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      // Data registered at this edge stand until the next one
      #1 chk("read data", exp, reg_rdata);
      @(posedge sys_clk);
   endtask : rd
   // One source period: high then low, giving one rise and one fall
   task automatic src_pulse();
      src_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      src_clk <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask : src_pulse
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   // ==========================================================
   // Scenarios
   task automatic t_reset_values();
      rd(OFS_ACC_LOW, 8'h00);
      rd(OFS_ACC_HIGH, 8'h00);
      rd(OFS_ACC_UPPER, 8'h00);
      rd(OFS_STEP_LOW, 8'h01);
      rd(OFS_STEP_HIGH, 8'h00);
      rd(OFS_STEP_UPPER, 8'h00);
   endtask : t_reset_values
   // Stopped module: full bytes, upper nibbles dropped, unmapped ignored
   task automatic t_bytes();
      wr(OFS_ACC_LOW, 8'ha5);
      wr(OFS_ACC_HIGH, 8'h5a);
      wr(OFS_ACC_UPPER, 8'hff);
      wr(OFS_STEP_UPPER, 8'hff);
      wr(4'h9, 8'hff);
      rd(OFS_ACC_LOW, 8'ha5);
      rd(OFS_ACC_HIGH, 8'h5a);
      rd(OFS_ACC_UPPER, 8'h0f);
      rd(OFS_STEP_UPPER, 8'h0f);
      rd(4'h9, 8'h00);
   endtask : t_bytes
   // Step 0x12345 times 15 edges wraps once and leaves 0x1110b
   task automatic t_accumulate();
      wr(OFS_STEP_UPPER, 8'h01);
      wr(OFS_STEP_HIGH, 8'h23);
      wr(OFS_STEP_LOW, 8'h45);
      rd(OFS_STATUS, 8'h02);
      src_pulse();
      rd(OFS_STATUS, 8'h00);
      wr(OFS_ACC_LOW, 8'h00);
      wr(OFS_ACC_HIGH, 8'h00);
      wr(OFS_ACC_UPPER, 8'h00);
      chk("overflows idle", 8'h00, 8'(ovf_n));
      wr(OFS_CONTROL, 8'h80);
      repeat (15) src_pulse();
      chk("overflows", 8'h01, 8'(ovf_n));
      chk("toggle out", 8'h01, {7'h00, oscillator_out});
      wr(OFS_CONTROL, 8'h00);
      rd(OFS_ACC_LOW, 8'h0b);
      rd(OFS_ACC_HIGH, 8'h11);
      rd(OFS_ACC_UPPER, 8'h01);
      chk("out cleared", 8'h00, {7'h00, oscillator_out});
   endtask : t_accumulate
   // Pulse mode: step 0x40000 overflows every 4th rise, pulse 2 periods
   task automatic t_pulse_mode();
      wr(OFS_STEP_UPPER, 8'h04);
      wr(OFS_STEP_HIGH, 8'h00);
      wr(OFS_STEP_LOW, 8'h00);
      src_pulse();
      wr(OFS_ACC_LOW, 8'h00);
      wr(OFS_ACC_HIGH, 8'h00);
      wr(OFS_ACC_UPPER, 8'h00);
      wr(OFS_CONTROL, 8'h91); // Width 2 within period 4
      rd(OFS_CONTROL, 8'h91);
      repeat (4) src_pulse();
      chk("pulse start", 8'h01, {7'h00, oscillator_out});
      src_pulse();
      chk("pulse held", 8'h01, {7'h00, oscillator_out});
      src_pulse();
      chk("pulse end", 8'h00, {7'h00, oscillator_out});
      chk("overflows pulse", 8'h02, 8'(ovf_n));
      wr(OFS_CONTROL, 8'h00);
   endtask : t_pulse_mode
   // Reset after the runs, module stopped, restores the accumulator and increment bytes
   task automatic t_mid_reset();
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk("out after reset", 8'h00, {7'h00, oscillator_out});
      t_reset_values();
   endtask : t_mid_reset
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reset_values();
      t_bytes();
      t_accumulate();
      t_pulse_mode();
      t_mid_reset();
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      end_sim();
   end
endmodule : nco_accumulator_increment_regs_tb
